// *** hw/thermal_voltage_result_regs.sv ***
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "thermal_defs.svh"
// Contract
// - 11-bit signed temperature, fault reads 80_00h
// - clamp readings to minus 64 .. 127.875
// - voltage mode puts voltage in high byte
// - voltage readings go to limit compare too
// - shutdown threshold read-only, resets to 7Fh
// - threshold refreshed at every monitor cycle end
// - threshold is unsigned whole degrees
// - four writable pushed temperatures, reset 00h
// - pushed temperatures never reach limit compare
// - pin voltage stored read-only, reset FFh
// - pin voltage bit weights 400 to 3.125 mV
// - reset loads every register default
// - unmapped reads give 00h, writes ignored
module thermal_voltage_result_regs
	import thermal_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Write address
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	// Write data
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// Write response
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// Read address
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	// Read data
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Conversion results
	input wire logic conv_done,
	input wire raw_temp_t [4:0] temp_raw,
	input wire logic [4:0] diode_fault,
	input wire logic [2:0] volt_mode,
	input wire logic [2:0][7:0] volt_data,
	input wire logic [7:0] trip_volt,
	input wire logic [7:0] trip_temp_calc,
	// Toward limit compare and look-up table
	output logic [4:0][7:0] limit_value,
	output logic limit_strobe,
	output logic [3:0][7:0] host_temp
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [15:0] encode_temp(input raw_temp_t raw, input logic fault);
		raw_temp_t s;
		s = raw;
		if (raw < `TEMP_MIN_EIGHTHS) begin
			s = `TEMP_MIN_EIGHTHS;
		end else if (raw > `TEMP_MAX_EIGHTHS) begin
			s = `TEMP_MAX_EIGHTHS;
		end
		if (fault) begin
			encode_temp = `FAULT_CODE;
		end else begin
			encode_temp = {s[10:0], 5'h00};
		end
	endfunction

	function automatic reg_idx_t addr_idx(input logic [7:0] addr);
		if (addr[7]) begin
			addr_idx = `IDX_NONE;
		end else begin
			addr_idx = addr[`ADDR_IDX_MSB:`ADDR_IDX_LSB];
		end
	endfunction

	function automatic logic is_host_idx(input reg_idx_t idx);
		is_host_idx = (idx >= `IDX_HOST_TEMP_1) && (idx <= `IDX_HOST_TEMP_4);
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	reg_byte_t [4:0] data_hi;
	frac_t [4:0] data_lo;
	frac_t [4:0] lo_shadow;
	reg_byte_t [4:0] next_hi;
	frac_t [4:0] next_lo;
	logic [15:0] code;
	reg_byte_t shutdown_temp;
	reg_byte_t pin_voltage;
	logic conv_q;
	logic aw_got;
	logic w_got;
	reg_idx_t aw_idx;
	reg_byte_t w_byte;
	logic w_lane0;
	logic do_write;
	logic next_aw_got;
	logic next_w_got;
	logic ar_take;
	logic ar_busy;
	logic next_ar_busy;
	reg_idx_t ar_idx;
	reg_idx_t ar_next_idx;
	reg_byte_t rd_byte;
	rd_state_t rd_state;

	host_temp_if ht();

	host_temp_mem u_host_temp_mem (
		.aclk(aclk),
		.aresetn(aresetn),
		.port(ht.mem)
	);

	assign host_temp = ht.values;

	// ----------------------------------------
	// Conversion results
	// ----------------------------------------
	always_comb begin
		code = 16'h0000;
		next_hi = '0;
		next_lo = '0;
		for (int ch = 0; ch < 5; ch++) begin
			code = encode_temp(temp_raw[ch], diode_fault[ch]);
			next_hi[ch] = code[15:8];
			next_lo[ch] = code[`FRAC_MSB:`FRAC_LSB];
			// Remote 1..3 double as voltage inputs; fraction has no meaning there
			if (ch >= 1 && ch <= 3 && volt_mode[ch - 1]) begin
				next_hi[ch] = volt_data[ch - 1];
				next_lo[ch] = 3'h0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			data_hi <= {5{`RST_TEMP_DATA}};
			data_lo <= '0;
		end else if (conv_done) begin
			data_hi <= next_hi;
			data_lo <= next_lo;
		end
	end

	// Computed threshold is taken whole-degree unsigned, never sign-extended
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			shutdown_temp <= `RST_SHUTDOWN_TEMP;
			pin_voltage <= `RST_PIN_VOLTAGE;
		end else if (conv_done) begin
			shutdown_temp <= trip_temp_calc;
			pin_voltage <= trip_volt;
		end
	end

	// ----------------------------------------
	// Limit compare feed
	// ----------------------------------------
	// Fed only from the measured data bytes, so pushed values cannot trip a limit
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			conv_q <= 1'b0;
			limit_strobe <= 1'b0;
			limit_value <= '0;
		end else begin
			conv_q <= conv_done;
			limit_strobe <= conv_q;
			if (conv_q) begin
				limit_value <= data_hi;
			end
		end
	end

	// ----------------------------------------
	// Write channel
	// ----------------------------------------
	assign do_write = aw_got && w_got && !bvalid;
	assign next_aw_got = (aw_got && !do_write) || (awvalid && awready);
	assign next_w_got = (w_got && !do_write) || (wvalid && wready);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got <= 1'b0;
			w_got <= 1'b0;
			awready <= 1'b0;
			wready <= 1'b0;
		end else begin
			aw_got <= next_aw_got;
			w_got <= next_w_got;
			awready <= !next_aw_got;
			wready <= !next_w_got;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_idx <= `IDX_NONE;
			w_byte <= 8'h00;
			w_lane0 <= 1'b0;
		end else begin
			if (awvalid && awready) begin
				aw_idx <= addr_idx(awaddr);
			end
			if (wvalid && wready) begin
				w_byte <= wdata[7:0];
				w_lane0 <= wstrb[0];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp <= `AXI_OKAY;
		end else if (do_write) begin
			bvalid <= 1'b1;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	// Only pushed temperatures accept data; everything else drops the write
	assign ht.wr_en = do_write && w_lane0 && is_host_idx(aw_idx);
	assign ht.wr_idx = aw_idx[1:0];
	assign ht.wr_data = w_byte;

	// ----------------------------------------
	// Read channel
	// ----------------------------------------
	assign ar_take = arvalid && arready;
	assign ar_next_idx = addr_idx(araddr);
	assign next_ar_busy = ar_take || (ar_busy && !(rvalid && rready));
	assign ht.rd_en = ar_take;
	assign ht.rd_idx = ar_next_idx[1:0];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ar_busy <= 1'b0;
			arready <= 1'b0;
			ar_idx <= `IDX_NONE;
		end else begin
			ar_busy <= next_ar_busy;
			arready <= !next_ar_busy;
			if (ar_take) begin
				ar_idx <= ar_next_idx;
			end
		end
	end

	always_comb begin
		rd_byte = 8'h00;
		if (ar_idx <= `IDX_REMOTE4_TEMP_LOW) begin
			if (ar_idx[0]) begin
				rd_byte = {lo_shadow[ar_idx[3:1]], 5'h00};
			end else begin
				rd_byte = data_hi[ar_idx[3:1]];
			end
		end else if (ar_idx == `IDX_SHUTDOWN_THRESHOLD_TEMP) begin
			rd_byte = shutdown_temp;
		end else if (is_host_idx(ar_idx)) begin
			rd_byte = ht.rd_data;
		end else if (ar_idx == `IDX_THRESHOLD_PIN_VOLTAGE) begin
			rd_byte = pin_voltage;
		end
	end

	// Host memory read data needs one edge, so answer on the edge after the take
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_state <= RD_IDLE;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= `AXI_OKAY;
		end else begin
			case (rd_state)
				RD_IDLE: begin
					if (ar_take) begin
						rd_state <= RD_ANSWER;
					end
				end
				RD_ANSWER: begin
					rvalid <= 1'b1;
					rdata <= {24'h00_0000, rd_byte};
					rd_state <= RD_WAIT;
				end
				RD_WAIT: begin
					if (rready) begin
						rvalid <= 1'b0;
						rd_state <= RD_IDLE;
					end
				end
				default: begin
					rvalid <= 1'b0;
					rd_state <= RD_IDLE;
				end
			endcase
		end
	end

	// Shadow is captured with the high byte so a later conversion cannot split them
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lo_shadow <= '0;
		end else if (rd_state == RD_ANSWER && ar_idx <= `IDX_REMOTE4_TEMP_LOW && !ar_idx[0]) begin
			lo_shadow[ar_idx[3:1]] <= data_lo[ar_idx[3:1]];
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_fault_code: assert property (conv_done && diode_fault[0] |=> data_hi[0] == 8'h80 && data_lo[0] == 3'h0)
		else $error("diode fault not coded as 80_00h");
	a_temp_clamp: assert property (conv_done && !diode_fault[4] && temp_raw[4] > `TEMP_MAX_EIGHTHS
		|=> data_hi[4] == 8'h7F && data_lo[4] == 3'h7)
		else $error("hot reading not clamped");
	a_volt_place: assert property (conv_done && volt_mode[0] |=> data_hi[1] == $past(volt_data[0])
		&& data_lo[1] == 3'h0)
		else $error("voltage not placed in high byte");
	a_limit_feed: assert property (conv_done |=> ##1 limit_strobe && limit_value[2] == data_hi[2])
		else $error("limit feed missed conversion");
	a_limit_quiet: assert property (!conv_q |=> $stable(limit_value))
		else $error("limit feed moved without conversion");
	a_thresh_hold: assert property (!conv_done |=> $stable(shutdown_temp))
		else $error("threshold changed outside monitor cycle");
	a_thresh_update: assert property (conv_done |=> shutdown_temp == $past(trip_temp_calc))
		else $error("threshold not refreshed");
	a_pin_volt: assert property (conv_done |=> pin_voltage == $past(trip_volt))
		else $error("pin voltage not stored");
	a_reset_value: assert property (disable iff (1'b0) !aresetn |=> shutdown_temp == 8'h7F
		&& pin_voltage == 8'hFF && data_hi == '0)
		else $error("register default wrong after reset");
	a_unmapped_read: assert property (ar_take && (ar_next_idx == `IDX_NONE || ar_next_idx == 5'h0B)
		|=> ##1 rvalid && rdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	a_shadow_load: assert property (rd_state == RD_ANSWER && ar_idx == `IDX_INTERNAL_TEMP_HIGH
		|=> lo_shadow[0] == $past(data_lo[0]))
		else $error("low byte not latched on high read");
	a_read_answer: assert property (ar_take |=> ##1 rvalid)
		else $error("read answer late");

	c_fault: cover property (conv_done && diode_fault[0]);
	c_volt: cover property (conv_done && volt_mode[2]);
	c_host_write: cover property (ht.wr_en);
	c_pair_read: cover property (rd_state == RD_ANSWER && ar_idx == `IDX_REMOTE1_TEMP_LOW);
endmodule // thermal_voltage_result_regs
`default_nettype wire

// *** hw/thermal_defs.svh ***
`ifndef THERMAL_DEFS_SVH
`define THERMAL_DEFS_SVH

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define IDX_INTERNAL_TEMP_HIGH 5'h00
`define IDX_INTERNAL_TEMP_LOW 5'h01
`define IDX_REMOTE1_TEMP_HIGH 5'h02
`define IDX_REMOTE1_TEMP_LOW 5'h03
`define IDX_REMOTE2_TEMP_HIGH 5'h04
`define IDX_REMOTE2_TEMP_LOW 5'h05
`define IDX_REMOTE3_TEMP_HIGH 5'h06
`define IDX_REMOTE3_TEMP_LOW 5'h07
`define IDX_REMOTE4_TEMP_HIGH 5'h08
`define IDX_REMOTE4_TEMP_LOW 5'h09
`define IDX_SHUTDOWN_THRESHOLD_TEMP 5'h0A
`define IDX_HOST_TEMP_1 5'h0C
`define IDX_HOST_TEMP_2 5'h0D
`define IDX_HOST_TEMP_3 5'h0E
`define IDX_HOST_TEMP_4 5'h0F
`define IDX_THRESHOLD_PIN_VOLTAGE 5'h10
`define IDX_NONE 5'h1F

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_TEMP_DATA 8'h00
`define RST_SHUTDOWN_TEMP 8'h7F
`define RST_HOST_TEMP 8'h00
`define RST_PIN_VOLTAGE 8'hFF

// ----------------------------------------
// Data format
// ----------------------------------------
`define FAULT_CODE 16'h8000
`define TEMP_MIN_EIGHTHS 13'sh1E00
`define TEMP_MAX_EIGHTHS 13'sh03FF
`define FRAC_MSB 7
`define FRAC_LSB 5
`define ADDR_IDX_MSB 6
`define ADDR_IDX_LSB 2
`define AXI_OKAY 2'h0

`endif

// *** hw/thermal_pkg.sv ***
package thermal_pkg;
	typedef logic [7:0] reg_byte_t;
	typedef logic [4:0] reg_idx_t;
	typedef logic [2:0] frac_t;
	typedef logic signed [12:0] raw_temp_t;
	typedef enum {RD_IDLE, RD_ANSWER, RD_WAIT} rd_state_t;
endpackage

// *** hw/host_temp_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface host_temp_if;
	logic wr_en;
	logic [1:0] wr_idx;
	logic [7:0] wr_data;
	logic rd_en;
	logic [1:0] rd_idx;
	logic [7:0] rd_data;
	logic [3:0][7:0] values;
	modport ctrl(output wr_en, wr_idx, wr_data, rd_en, rd_idx, input rd_data, values);
	modport mem(input wr_en, wr_idx, wr_data, rd_en, rd_idx, output rd_data, values);
endinterface // host_temp_if
`default_nettype wire

// *** hw/host_temp_mem.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "thermal_defs.svh"
module host_temp_mem (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Access port
	host_temp_if.mem port
);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			port.values <= {4{`RST_HOST_TEMP}};
		end else if (port.wr_en) begin
			port.values[port.wr_idx] <= port.wr_data;
		end
	end

	// Read data held in a register so the bus mux sees a stable byte
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			port.rd_data <= 8'h00;
		end else if (port.rd_en) begin
			port.rd_data <= port.values[port.rd_idx];
		end
	end

	a_host_write: assert property (@(posedge aclk) disable iff (!aresetn)
		port.wr_en |=> port.values[$past(port.wr_idx)] == $past(port.wr_data))
		else $error("pushed temperature write not stored");
endmodule // host_temp_mem
`default_nettype wire

// *** tb/axi_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module axi_host_model (
	// Clock
	input wire logic aclk,
	// Write channels
	output logic [7:0] awaddr,
	output logic awvalid,
	input wire logic awready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	output logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	output logic bready,
	// Read channels
	output logic [7:0] araddr,
	output logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic rvalid,
	output logic rready
);
	initial begin
		awaddr = 8'h00;
		awvalid = 1'b0;
		wdata = 32'h0;
		wstrb = 4'h0;
		wvalid = 1'b0;
		bready = 1'b0;
		araddr = 8'h00;
		arvalid = 1'b0;
		rready = 1'b0;
	end

	// Pushed temperatures travel as signed whole degrees in the low byte
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge aclk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wstrb <= s;
		wvalid <= 1'b1;
		bready <= 1'b1;
		// No cycle limit here; only the bench watchdog ends a stuck wait
		do begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (!rvalid);
		d = rdata;
		rready <= 1'b0;
	endtask
endmodule // axi_host_model
`default_nettype wire

// *** tb/thermal_voltage_result_regs_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module thermal_voltage_result_regs_tb;
	import thermal_pkg::*;
	logic aclk, aresetn, conv_done, limit_strobe;
	logic [7:0] awaddr, araddr, trip_volt, trip_temp_calc;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	raw_temp_t [4:0] temp_raw;
	logic [4:0] diode_fault;
	logic [2:0] volt_mode;
	logic [2:0][7:0] volt_data;
	logic [4:0][7:0] limit_value;
	logic [3:0][7:0] host_temp;
	logic [7:0] ro [5] = '{8'h00, 8'h28, 8'h40, 8'h2C, 8'h80};
	logic [7:0] hv [4];
	logic [15:0] e;
	int fail_count, tests_run, conv_count, strobe_count, i, k, c;

	thermal_voltage_result_regs u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .conv_done(conv_done),
		.temp_raw(temp_raw), .diode_fault(diode_fault), .volt_mode(volt_mode), .volt_data(volt_data),
		.trip_volt(trip_volt), .trip_temp_calc(trip_temp_calc), .limit_value(limit_value),
		.limit_strobe(limit_strobe), .host_temp(host_temp));
	axi_host_model u_host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rvalid(rvalid),
		.rready(rready));

	always #5 aclk = ~aclk;
	always @(posedge aclk) begin
		if (limit_strobe) strobe_count++;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic rchk(input logic [7:0] a, input logic [7:0] x);
		logic [31:0] d;
		u_host.rd(a, d);
		chk(d, {24'h0, x});
	endtask

	function automatic logic [15:0] enc(input int ch);
		int v;
		if (ch > 0 && ch < 4 && volt_mode[ch-1]) return {volt_data[ch-1], 8'h00};
		if (diode_fault[ch]) return 16'h8000;
		v = temp_raw[ch];
		if (v < -512) v = -512;
		if (v > 1023) v = 1023;
		return {v[10:0], 5'h00};
	endfunction

	// Corner set: fault on internal, clamp both ends, minus one eighth, one degree
	task automatic convert(input bit corner);
		int n;
		logic [15:0] ex;
		@(posedge aclk);
		if (corner) begin
			temp_raw <= {13'sd1200, -13'sd1, 13'sd8, -13'sd600, 13'sd0};
		end else begin
			for (n = 0; n < 5; n++) temp_raw[n] <= raw_temp_t'(int'($urandom_range(0, 2200)) - 700);
		end
		diode_fault <= corner ? 5'h01 : 5'($urandom_range(0, 31));
		volt_mode <= corner ? 3'h0 : 3'($urandom);
		volt_data <= 24'($urandom);
		trip_volt <= 8'($urandom);
		trip_temp_calc <= corner ? 8'h96 : 8'($urandom);
		conv_done <= 1'b1;
		@(posedge aclk);
		conv_done <= 1'b0;
		conv_count++;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (!limit_strobe && n < 10);
		// Local expectation so a caller's saved value survives a conversion
		for (n = 0; n < 5; n++) begin
			ex = enc(n);
			chk({24'h0, limit_value[n]}, {24'h0, ex[15:8]});
		end
	endtask

	task automatic results();
		$display("comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge aclk);
		fail_count++;
		results();
	end

	initial begin
		aclk = 1'b0;
		aresetn = 1'b0;
		conv_done = 1'b0;
		temp_raw = '0;
		diode_fault = 5'h00;
		volt_mode = 3'h0;
		volt_data = '0;
		trip_volt = 8'h00;
		trip_temp_calc = 8'h00;
		void'($urandom(14964));
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		// ----------------------------------------
		// Defaults and unmapped reads
		// ----------------------------------------
		for (i = 0; i < 18; i++) rchk(8'(i * 4), i == 10 ? 8'h7F : (i == 16 ? 8'hFF : 8'h00));
		rchk(8'h80, 8'h00);
		chk(32'(rresp), 32'h0);
		// ----------------------------------------
		// Writes that must be dropped
		// ----------------------------------------
		foreach (ro[i]) u_host.wr(ro[i], 32'hFFFFFFFF, 4'hF);
		u_host.wr(8'h30, 32'h000000A5, 4'h0);
		chk(32'(bresp), 32'h0);
		rchk(8'h28, 8'h7F);
		rchk(8'h40, 8'hFF);
		rchk(8'h2C, 8'h00);
		rchk(8'h00, 8'h00);
		rchk(8'h30, 8'h00);
		// ----------------------------------------
		// Pushed temperatures, back to back
		// ----------------------------------------
		for (i = 0; i < 4; i++) begin
			hv[i] = 8'($urandom);
			u_host.wr(8'(8'h30 + 4 * i), {24'h0, hv[i]}, 4'h1);
		end
		for (i = 0; i < 4; i++) begin
			rchk(8'(8'h30 + 4 * i), hv[i]);
			chk({24'h0, host_temp[i]}, {24'h0, hv[i]});
		end
		// ----------------------------------------
		// Conversions
		// ----------------------------------------
		for (k = 0; k < 6; k++) begin
			convert(k == 0);
			rchk(8'h28, trip_temp_calc);
			rchk(8'h40, trip_volt);
			for (c = 0; c < 5; c++) begin
				e = enc(c);
				rchk(8'(8 * c), e[15:8]);
				rchk(8'(8 * c + 4), e[7:0]);
			end
		end
		// Low byte stays with the high byte read before a newer result
		e = enc(2);
		rchk(8'h10, e[15:8]);
		convert(1'b0);
		rchk(8'h14, e[7:0]);
		chk(32'(strobe_count), 32'(conv_count));
		results();
	end
endmodule // thermal_voltage_result_regs_tb
`default_nettype wire
